// *** hdl/codec_ctrl_pkg.sv ***
// constants, register map and types for the codec serial control port
package codec_ctrl_pkg;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 9;
    localparam int STAT_W = 8;
    localparam int CHAN_STAT_N = 5;

    // register addresses
    localparam logic [6:0] DEV_ID0_ADDR = 7'h00;
    localparam logic [6:0] DEV_ID1_ADDR = 7'h01;
    localparam logic [6:0] DEV_ID2_ADDR = 7'h02;
    localparam logic [6:0] RB_CTRL_ADDR = 7'h34;
    localparam logic [6:0] SOFT_RESET_ADDR = 7'h35;
    localparam logic [6:0] STAT_ERR_ADDR = 7'h36;
    localparam logic [6:0] CHAN_STAT1_ADDR = 7'h37;
    localparam logic [6:0] TRX_STAT_ADDR = 7'h3C;

    // readback control fields
    localparam int RB_SEL_LSB = 0;
    localparam int RB_SEL_W = 3;
    localparam int RB_CONT_BIT = 3;
    localparam int RB_EN_BIT = 4;
    localparam logic [8:0] RB_CTRL_RST = 9'h000;

    // readback select codes
    localparam logic [2:0] RB_SEL_ERR = 3'h0;
    localparam logic [2:0] RB_SEL_CS1 = 3'h1;
    localparam logic [2:0] RB_SEL_CS5 = 3'h5;
    localparam logic [2:0] RB_SEL_TRX = 3'h6;

    // 2-wire device addresses, chosen by the chip-select pin level
    localparam logic [6:0] TWI_ADDR_LOW = 7'h1A;
    localparam logic [6:0] TWI_ADDR_HIGH = 7'h1B;

    // 3-wire frame: readback byte leaves after these rising-edge counts
    localparam logic [4:0] FRAME3_BITS = 5'h10;
    localparam logic [4:0] LINK_RB_FIRST = 5'h07;
    localparam logic [4:0] LINK_RB_LAST = 5'h0E;

    typedef enum logic [2:0] {
        TWI_IDLE = 3'b000,
        TWI_ADDR = 3'b001,
        TWI_ADDR_ACK = 3'b010,
        TWI_DATA1 = 3'b011,
        TWI_DATA1_ACK = 3'b100,
        TWI_DATA2 = 3'b101,
        TWI_DATA2_ACK = 3'b110,
        TWI_DONE = 3'b111
    } twi_state_t;
endpackage

// *** hdl/codec_ctrl_port.sv ***
// serial control port of the codec: 3-wire and 2-wire register writes with readback
//
// Behaviour
// - strap low selects software control, high hardware
// - wire strap low 2-wire, high 3-wire
// - 3-wire data sampled on serial clock rise
// - 3-wire word: 7 address bits, 9 data
// - chip-select rising edge commits 3-wire word
// - only ID and status registers read back
// - readback drives data-out only when enabled
// - continuous mode returns selected status byte, zero after a readback control write
// - select: error, channel status 1-5, transceiver
// - non-continuous returns written readable register
// - 3-wire data-out floats unless chip select low
// - start condition prepares device to receive
// - shift seven address bits plus direction
// - matching address acknowledged by pulling low
// - mismatch: idle until next start
// - first byte: register address, data bit 8
// - second byte: low eight data bits, acknowledged
// - stop condition returns device to idle
// - out-of-sequence start/stop abandons transfer
// - chip-select pin picks 2-wire device address
// - 2-wire offers same readback methods
// - write to reset address restores defaults
`timescale 1ns/1ps
`default_nettype none
module codec_ctrl_port #(
    parameter logic [7:0] DEV_ID0 = 8'h5A, // arbitrary value
    parameter logic [7:0] DEV_ID1 = 8'hC3, // arbitrary value
    parameter logic [7:0] DEV_ID2 = 8'h01  // arbitrary value
) (
    // system
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    // straps
    input wire logic CONTROL_STYLE_STRAP_I,
    input wire logic WIRE_COUNT_STRAP_I,
    // serial link
    input wire logic SERIAL_CLK_I,
    input wire logic CHIP_SELECT_N_I,
    input wire logic SERIAL_DATA_IN_I,
    output logic SERIAL_DATA_IN_O,
    output logic SERIAL_DATA_IN_OE_O,
    output logic SERIAL_DATA_OUT_O,
    output logic SERIAL_DATA_OUT_OE_O,
    // status sources
    input wire logic [codec_ctrl_pkg::STAT_W-1:0] STATUS_ERROR_I,
    input wire logic [codec_ctrl_pkg::CHAN_STAT_N*codec_ctrl_pkg::STAT_W-1:0] CHAN_STATUS_I,
    input wire logic [codec_ctrl_pkg::STAT_W-1:0] TRX_STATUS_I,
    // register write port towards the control registers
    output logic HW_CONTROL_O,
    output logic THREE_WIRE_O,
    output logic REG_WR_O,
    output logic [codec_ctrl_pkg::ADDR_W-1:0] REG_ADDR_O,
    output logic [codec_ctrl_pkg::DATA_W-1:0] REG_DATA_O,
    output logic SOFT_RESET_O,
    output logic [codec_ctrl_pkg::DATA_W-1:0] READBACK_CONTROL_O
);
    import codec_ctrl_pkg::*;

    typedef struct packed {
        logic cs_meta;
        logic cs_sync;
        logic cs_prev;
        logic scl_meta;
        logic scl_sync;
        logic scl_prev;
        logic sda_meta;
        logic sda_sync;
        logic sda_prev;
        logic hw_meta;
        logic hw_sync;
        logic wc_meta;
        logic wc_sync;
        logic hw_mode;
        logic three_wire;
        twi_state_t twi_state;
        logic [2:0] bit_cnt;
        logic [7:0] shreg;
        logic [6:0] addr_hold;
        logic d8;
        logic sda_oe;
        logic [8:0] rb_ctrl;
        logic [7:0] rb_byte;
        logic wr;
        logic [6:0] wr_addr;
        logic [8:0] wr_data;
        logic soft_rst;
        logic sdo2;
        logic sdo_oe;
    } sys_state_t;

    typedef struct packed {
        logic [4:0] cnt;
        logic serial_data_out;
    } link_state_t;

    sys_state_t q;
    sys_state_t n;
    link_state_t lq;
    link_state_t ln;
    logic [15:0] word_ff;

    function automatic logic [7:0] select_status(input logic [2:0] sel,
                                                  input logic [7:0] err,
                                                  input logic [39:0] chan,
                                                  input logic [7:0] trx);
        logic [7:0] v;
        v = 8'h00;
        if (sel == RB_SEL_ERR) begin
            v = err;
        end else if (sel >= RB_SEL_CS1 && sel <= RB_SEL_CS5) begin
            v = chan[(int'(sel) - 1) * STAT_W +: STAT_W];
        end else if (sel == RB_SEL_TRX) begin
            v = trx;
        end
        return v;
    endfunction

    // byte returned after a write; in non-continuous mode non-readable registers give zero
    function automatic logic [7:0] readback_byte(input logic [6:0] addr,
                                                  input logic [8:0] ctrl,
                                                  input logic [7:0] err,
                                                  input logic [39:0] chan,
                                                  input logic [7:0] trx);
        logic [7:0] v;
        v = 8'h00;
        if (ctrl[RB_CONT_BIT]) begin
            if (addr != RB_CTRL_ADDR) begin
                v = select_status(ctrl[RB_SEL_LSB +: RB_SEL_W], err, chan, trx);
            end
        end else begin
            case (addr)
                DEV_ID0_ADDR: v = DEV_ID0;
                DEV_ID1_ADDR: v = DEV_ID1;
                DEV_ID2_ADDR: v = DEV_ID2;
                STAT_ERR_ADDR: v = err;
                TRX_STAT_ADDR: v = trx;
                default: begin
                    if (addr >= CHAN_STAT1_ADDR && addr < TRX_STAT_ADDR) begin
                        v = chan[int'(addr - CHAN_STAT1_ADDR) * STAT_W +: STAT_W];
                    end
                end
            endcase
        end
        return v;
    endfunction

    logic cs_rise;
    logic scl_rise;
    logic scl_fall;
    logic twi_start;
    logic twi_stop;
    logic twi_on;
    logic [6:0] own_addr;

    assign cs_rise = q.cs_sync & ~q.cs_prev;
    assign scl_rise = q.scl_sync & ~q.scl_prev;
    assign scl_fall = ~q.scl_sync & q.scl_prev;
    assign twi_start = q.scl_sync & q.scl_prev & q.sda_prev & ~q.sda_sync;
    assign twi_stop = q.scl_sync & q.scl_prev & ~q.sda_prev & q.sda_sync;
    assign twi_on = ~q.hw_mode & ~q.three_wire;
    assign own_addr = q.cs_sync ? TWI_ADDR_HIGH : TWI_ADDR_LOW;

    // system domain: synchronisers, 2-wire engine, commit and readback
    always_comb begin
        logic commit;
        logic [6:0] c_addr;
        logic [8:0] c_data;
        commit = 1'b0;
        c_addr = 7'h00;
        c_data = 9'h000;
        n = q;
        n.cs_meta = CHIP_SELECT_N_I;
        n.cs_sync = q.cs_meta;
        n.cs_prev = q.cs_sync;
        n.scl_meta = SERIAL_CLK_I;
        n.scl_sync = q.scl_meta;
        n.scl_prev = q.scl_sync;
        n.sda_meta = SERIAL_DATA_IN_I;
        n.sda_sync = q.sda_meta;
        n.sda_prev = q.sda_sync;
        n.hw_meta = CONTROL_STYLE_STRAP_I;
        n.hw_sync = q.hw_meta;
        n.wc_meta = WIRE_COUNT_STRAP_I;
        n.wc_sync = q.wc_meta;
        n.hw_mode = q.hw_sync;
        n.three_wire = q.wc_sync;
        n.wr = 1'b0;
        n.soft_rst = 1'b0;

        // shift word is idle while chip select is high, so it can be read here
        if (~q.hw_mode && q.three_wire && cs_rise) begin
            commit = 1'b1;
            c_addr = word_ff[15:9];
            c_data = word_ff[8:0];
        end

        if (~twi_on) begin
            n.twi_state = TWI_IDLE;
            n.sda_oe = 1'b0;
        end else if (twi_start) begin
            n.twi_state = TWI_ADDR;
            n.bit_cnt = 3'h0;
            n.sda_oe = 1'b0;
        end else if (twi_stop) begin
            n.twi_state = TWI_IDLE;
            n.sda_oe = 1'b0;
        end else begin
            case (q.twi_state)
                TWI_ADDR, TWI_DATA1, TWI_DATA2: begin
                    if (scl_rise) begin
                        n.shreg = {q.shreg[6:0], q.sda_sync};
                        n.bit_cnt = q.bit_cnt + 3'h1;
                        if (q.bit_cnt == 3'h7) begin
                            case (q.twi_state)
                                TWI_ADDR: n.twi_state = TWI_ADDR_ACK;
                                TWI_DATA1: n.twi_state = TWI_DATA1_ACK;
                                default: n.twi_state = TWI_DATA2_ACK;
                            endcase
                        end
                    end
                end
                TWI_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (~q.sda_oe) begin
                            if (q.shreg[7:1] == own_addr) begin
                                n.sda_oe = 1'b1;
                            end else begin
                                n.twi_state = TWI_IDLE;
                            end
                        end else begin
                            n.sda_oe = 1'b0;
                            n.twi_state = TWI_DATA1;
                        end
                    end
                end
                TWI_DATA1_ACK: begin
                    if (scl_fall) begin
                        if (~q.sda_oe) begin
                            n.sda_oe = 1'b1;
                            n.addr_hold = q.shreg[7:1];
                            n.d8 = q.shreg[0];
                        end else begin
                            n.sda_oe = 1'b0;
                            n.twi_state = TWI_DATA2;
                        end
                    end
                end
                TWI_DATA2_ACK: begin
                    if (scl_fall) begin
                        if (~q.sda_oe) begin
                            n.sda_oe = 1'b1;
                        end else begin
                            n.sda_oe = 1'b0;
                            n.twi_state = TWI_DONE;
                            commit = 1'b1;
                            c_addr = q.addr_hold;
                            c_data = {q.d8, q.shreg};
                        end
                    end
                end
                TWI_IDLE, TWI_DONE: begin
                    n.sda_oe = 1'b0;
                end
                default: begin
                    n.twi_state = TWI_IDLE;
                end
            endcase
        end

        if (commit) begin
            n.wr = 1'b1;
            n.wr_addr = c_addr;
            n.wr_data = c_data;
            if (c_addr == RB_CTRL_ADDR) begin
                n.rb_ctrl = c_data;
            end
            if (c_addr == SOFT_RESET_ADDR) begin
                n.rb_ctrl = RB_CTRL_RST;
                n.soft_rst = 1'b1;
            end
            n.rb_byte = readback_byte(c_addr, n.rb_ctrl, STATUS_ERROR_I,
                                      CHAN_STATUS_I, TRX_STATUS_I);
        end

        // 2-wire readback moves on clock low; enable holds into the ack so bit 0 is seen
        if (scl_fall) begin
            n.sdo2 = (n.twi_state == TWI_DATA2) ? q.rb_byte[3'h7 - n.bit_cnt] : 1'b0;
        end
        if (q.hw_mode) begin
            n.sdo_oe = 1'b0;
        end else if (q.three_wire) begin
            n.sdo_oe = q.rb_ctrl[RB_EN_BIT] & ~q.cs_sync;
        end else begin
            n.sdo_oe = q.rb_ctrl[RB_EN_BIT] & (n.twi_state == TWI_DATA2 ||
                (n.twi_state == TWI_DATA2_ACK && !n.sda_oe));
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            q <= '0;
            q.rb_ctrl <= RB_CTRL_RST;
        end else begin
            q <= n;
        end
    end

    // link domain: frames are bounded by chip select, so it clears the count
    always_ff @(posedge SERIAL_CLK_I) begin
        if (~CHIP_SELECT_N_I) begin
            word_ff <= {word_ff[14:0], SERIAL_DATA_IN_I};
        end
    end

    // rb_byte only changes between frames, while this clock stands still
    always_comb begin
        ln = lq;
        if (lq.cnt != FRAME3_BITS) begin
            ln.cnt = lq.cnt + 5'h01;
        end
        ln.serial_data_out = 1'b0;
        if (lq.cnt >= LINK_RB_FIRST && lq.cnt <= LINK_RB_LAST) begin
            ln.serial_data_out = q.rb_byte[3'(LINK_RB_LAST - lq.cnt)];
        end
    end

    always_ff @(posedge SERIAL_CLK_I or posedge CHIP_SELECT_N_I) begin
        if (CHIP_SELECT_N_I) begin
            lq <= '0;
        end else begin
            lq <= ln;
        end
    end

    assign SERIAL_DATA_IN_O = 1'b0;
    assign SERIAL_DATA_IN_OE_O = q.sda_oe;
    assign SERIAL_DATA_OUT_O = q.three_wire ? lq.serial_data_out : q.sdo2;
    assign SERIAL_DATA_OUT_OE_O = q.sdo_oe;
    assign HW_CONTROL_O = q.hw_mode;
    assign THREE_WIRE_O = q.three_wire;
    assign REG_WR_O = q.wr;
    assign REG_ADDR_O = q.wr_addr;
    assign REG_DATA_O = q.wr_data;
    assign SOFT_RESET_O = q.soft_rst;
    assign READBACK_CONTROL_O = q.rb_ctrl;

    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);

    a_hw_no_write: assert property (q.hw_mode |-> ##1 !q.wr)
        else $error("write taken in hardware control mode");
    a_wire_mode_sel: assert property (q.three_wire |=> q.twi_state == TWI_IDLE)
        else $error("2-wire engine active in 3-wire mode");
    a_cs_commit: assert property (!q.hw_mode && q.three_wire && cs_rise |=>
        q.wr && q.wr_addr == $past(word_ff[15:9]) && q.wr_data == $past(word_ff[8:0]))
        else $error("3-wire word not committed on chip-select rise");
    a_sdo_float: assert property (q.sdo_oe && q.three_wire |->
        $past(!q.cs_sync) && $past(q.rb_ctrl[RB_EN_BIT]))
        else $error("data-out driven without chip select or enable");
    a_start_recv: assert property (twi_on && twi_start |=>
        q.twi_state == TWI_ADDR && q.bit_cnt == 3'h0 && !q.sda_oe)
        else $error("start condition not honoured");
    a_addr_ack: assert property (q.twi_state == TWI_ADDR_ACK && q.sda_oe |->
        q.shreg[7:1] == own_addr)
        else $error("acknowledge for a foreign address");
    a_addr_miss: assert property (twi_on && q.twi_state == TWI_ADDR_ACK && !q.sda_oe
        && scl_fall && !twi_start && !twi_stop && q.shreg[7:1] != own_addr
        |=> q.twi_state == TWI_IDLE [*2])
        else $error("mismatched address not dropped");
    a_stop_idle: assert property (twi_on && twi_stop && !twi_start |=>
        q.twi_state == TWI_IDLE && !q.sda_oe)
        else $error("stop did not return to idle");
    a_twi_commit: assert property (q.wr && !q.three_wire |->
        $past(q.twi_state) == TWI_DATA2_ACK && $past(q.sda_oe))
        else $error("2-wire write before second acknowledge");
    a_soft_reset: assert property (q.soft_rst |->
        q.wr && q.wr_addr == SOFT_RESET_ADDR && q.rb_ctrl == RB_CTRL_RST)
        else $error("software reset did not restore defaults");
    a_cont_status: assert property (q.wr && q.rb_ctrl[RB_CONT_BIT]
        && q.wr_addr != RB_CTRL_ADDR |-> q.rb_byte == select_status(
        q.rb_ctrl[RB_SEL_LSB +: RB_SEL_W], $past(STATUS_ERROR_I),
        $past(CHAN_STATUS_I), $past(TRX_STATUS_I)))
        else $error("continuous readback returned wrong status");
    a_link_sample: assert property (@(posedge SERIAL_CLK_I) disable iff (CHIP_SELECT_N_I)
        !$past(CHIP_SELECT_N_I) |-> word_ff[0] == $past(SERIAL_DATA_IN_I))
        else $error("serial data not sampled on clock rise");

    c_three_wire_wr: cover property (q.wr && q.three_wire);
    c_two_wire_wr: cover property (q.wr && !q.three_wire);
    c_soft_reset: cover property (q.soft_rst);
    c_addr_ack: cover property (q.twi_state == TWI_ADDR_ACK && q.sda_oe);
endmodule
`default_nettype wire

// *** test/codec_host_model.sv ***
// host model: drives 3-wire frames and 2-wire transfers, captures readback
`timescale 1ns/1ps
`default_nettype none
module codec_host_model (
    // link pins
    output logic sclk_o,
    output logic cs_n_o,
    output logic sda_o,
    // device pins
    input wire logic sda_i,
    input wire logic sdo_i,
    input wire logic sdo_oe_i
);
    localparam int H = 1000;
    logic [7:0] rb_byte;
    logic oe_seen;
    logic [2:0] acks;
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        sda_o = 1'b1;
    end
    // link clock 64 ns, still between frames
    task automatic spi(input logic [6:0] a, input logic [8:0] d);
        logic [15:0] w;
        w = {a, d};
        oe_seen = 1'b0;
        #7 cs_n_o = 1'b0;
        for (int i = 0; i < 16; i++) begin
            sda_o = w[15-i];
            #32;
            if (i >= 8) begin
                // an undriven data-out pin reads inverted, so a missing enable shows up
                rb_byte = {rb_byte[6:0], sdo_oe_i ? sdo_i : ~sdo_i};
                oe_seen = oe_seen | sdo_oe_i;
            end
            sclk_o = 1'b1;
            #32 sclk_o = 1'b0;
        end
        #32 cs_n_o = 1'b1;
        // released line shows the inverse so a stale bit cannot pass
        sda_o = ~sda_o;
        #400;
    endtask
    // data moves an eighth of a period after the fall, away from the clock edge
    task automatic clk2(input logic b, output logic s, output logic q);
        #(H/4) sda_o = b;
        #(H*3/4) sclk_o = 1'b1;
        #(H/2) s = sda_i;
        q = sdo_oe_i ? sdo_i : ~sdo_i;
        #(H/2) sclk_o = 1'b0;
    endtask
    task automatic byte2(input logic [7:0] v, input int k);
        logic s;
        logic q;
        for (int i = 7; i >= 0; i--) begin
            clk2(v[i], s, q);
            if (k == 2) rb_byte = {rb_byte[6:0], q};
        end
        clk2(1'b1, s, q);
        acks = {acks[1:0], ~s};
    endtask
    task automatic twi(input logic csp, input logic [6:0] dev, input logic [6:0] a,
                       input logic [8:0] d, input logic early_stop);
        acks = 3'b000;
        cs_n_o = csp;
        sda_o = 1'b1;
        #H sclk_o = 1'b1;
        #H sda_o = 1'b0;
        #H sclk_o = 1'b0;
        byte2({dev, 1'b0}, 0);
        byte2({a, d[8]}, 1);
        if (!early_stop) byte2(d[7:0], 2);
        #(H/4) sda_o = 1'b0;
        #H sclk_o = 1'b1;
        #H sda_o = 1'b1;
        #H;
    endtask
endmodule
`default_nettype wire

// *** test/codec_ctrl_port_tb.sv ***
// self-checking bench for the codec serial control port
`timescale 1ns/1ps
`default_nettype none
module codec_ctrl_port_tb;
    import codec_ctrl_pkg::*;
    localparam logic [7:0] ID0 = 8'h3C; // arbitrary value
    localparam logic [7:0] ID1 = 8'h96; // arbitrary value
    localparam logic [7:0] ID2 = 8'h07; // arbitrary value
    logic clk = 1'b0;
    logic rst, hw_strap, wire_strap, sdi_o, sdi_oe, serial_data_out, sdo_oe, sclk, cs_n, host_sda;
    logic hw_ctl, three_w, reg_wr, soft_rst, w_soft;
    logic [7:0] err_st, trx_st;
    logic [39:0] chan_st;
    logic [6:0] reg_addr, w_addr;
    logic [8:0] reg_data, rb_ctrl, w_data, c;
    logic [6:0] rd_list [0:6] = '{7'h00, 7'h01, 7'h02, 7'h36, 7'h38, 7'h3C, 7'h11};
    wire sda;
    int num_errors = 0;
    int total_checks = 0;
    int wr_cnt = 0;
    int cycles = 0;
    assign sda = sdi_oe ? sdi_o : host_sda;
    always #25 clk = ~clk;
    codec_ctrl_port #(.DEV_ID0(ID0), .DEV_ID1(ID1), .DEV_ID2(ID2)) codec_ctrl_port_i (
        .CLK_SYS_I(clk), .RST_I(rst), .CONTROL_STYLE_STRAP_I(hw_strap),
        .WIRE_COUNT_STRAP_I(wire_strap), .SERIAL_CLK_I(sclk), .CHIP_SELECT_N_I(cs_n),
        .SERIAL_DATA_IN_I(sda), .SERIAL_DATA_IN_O(sdi_o), .SERIAL_DATA_IN_OE_O(sdi_oe),
        .SERIAL_DATA_OUT_O(serial_data_out), .SERIAL_DATA_OUT_OE_O(sdo_oe), .STATUS_ERROR_I(err_st),
        .CHAN_STATUS_I(chan_st), .TRX_STATUS_I(trx_st), .HW_CONTROL_O(hw_ctl),
        .THREE_WIRE_O(three_w), .REG_WR_O(reg_wr), .REG_ADDR_O(reg_addr),
        .REG_DATA_O(reg_data), .SOFT_RESET_O(soft_rst), .READBACK_CONTROL_O(rb_ctrl));
    codec_host_model host_i (.sclk_o(sclk), .cs_n_o(cs_n), .sda_o(host_sda), .sda_i(sda),
        .sdo_i(serial_data_out), .sdo_oe_i(sdo_oe));
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (reg_wr === 1'b1) begin
            wr_cnt <= wr_cnt + 1;
            w_addr <= reg_addr;
            w_data <= reg_data;
            w_soft <= soft_rst;
        end
        if (cycles == 20000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    function automatic logic [7:0] exp_rb(input logic [6:0] a, input logic [8:0] k);
        if (k[RB_CONT_BIT] && k[2:0] == RB_SEL_ERR) return err_st;
        else if (k[RB_CONT_BIT] && k[2:0] == RB_SEL_TRX) return trx_st;
        else if (k[RB_CONT_BIT]) return chan_st[8*(k[2:0]-1) +: 8];
        else if (a == DEV_ID0_ADDR) return ID0;
        else if (a == DEV_ID1_ADDR) return ID1;
        else if (a == DEV_ID2_ADDR) return ID2;
        else if (a == STAT_ERR_ADDR) return err_st;
        else if (a == TRX_STAT_ADDR) return trx_st;
        else if (a > STAT_ERR_ADDR && a < TRX_STAT_ADDR)
            return chan_st[8*(a-CHAN_STAT1_ADDR) +: 8];
        return 8'h00;
    endfunction
    // one 3-wire frame and its effect at the register side
    task automatic wr3(input logic [6:0] a, input logic [8:0] d, input bit ok);
        int n;
        n = wr_cnt;
        host_i.spi(a, d);
        chk(wr_cnt - n, ok, "write count");
        if (ok) chk({w_addr, w_data}, {a, d}, "write word");
        if (ok) chk(w_soft, a == SOFT_RESET_ADDR, "soft reset flag");
        chk(sdo_oe, 1'b0, "data-out enable while deselected");
    endtask
    // the frame after a write carries the readback byte of that write
    task automatic rb3(input logic [6:0] a, input logic [7:0] e);
        wr3(a, 9'($urandom), 1'b1);
        wr3(7'h11, 9'($urandom), 1'b1);
        chk(host_i.rb_byte, e, "readback byte");
        chk(host_i.oe_seen, 1'b1, "data-out driven");
    endtask
    task automatic wr2(input logic csp, input logic [6:0] dev, input logic [6:0] a,
                       input logic [8:0] d, input logic st, input logic [2:0] ea, input bit ok);
        int n;
        n = wr_cnt;
        host_i.twi(csp, dev, a, d, st);
        chk(host_i.acks, ea, "acknowledges");
        chk(wr_cnt - n, ok, "2-wire write count");
        if (ok) chk({w_addr, w_data}, {a, d}, "2-wire word");
    endtask
    initial begin
        rst = 1'b1;
        hw_strap = 1'b0;
        wire_strap = 1'b1;
        err_st = 8'h00;
        trx_st = 8'h00;
        chan_st = 40'h0;
        void'($urandom(32'h420d));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        err_st <= 8'($urandom);
        trx_st <= 8'($urandom);
        chan_st <= {$urandom, 8'($urandom)};
        repeat (6) @(posedge clk);
        chk({hw_ctl, three_w, reg_wr, sdi_oe, sdo_oe}, 5'h08, "outputs after reset");
        chk(rb_ctrl, RB_CTRL_RST, "readback control reset");
        $display("test reset done");
        wr3(7'h7F, 9'h1FF, 1'b1);
        wr3(7'h00, 9'h000, 1'b1);
        for (int i = 0; i < 8; i++) wr3(7'($urandom_range(51)), 9'($urandom), 1'b1);
        $display("test 3-wire writes done");
        for (int s = 0; s < 7; s++) begin
            c = 9'h018 | 9'(s);
            wr3(RB_CTRL_ADDR, c, 1'b1);
            chk(rb_ctrl, c, "readback control");
            rb3(7'h22, exp_rb(7'h22, c));
        end
        $display("test continuous readback done");
        wr3(RB_CTRL_ADDR, 9'h010, 1'b1);
        for (int i = 0; i < 7; i++) rb3(rd_list[i], exp_rb(rd_list[i], 9'h010));
        $display("test direct readback done");
        wr3(RB_CTRL_ADDR, 9'h00E, 1'b1);
        wr3(7'h22, 9'h033, 1'b1);
        wr3(7'h11, 9'h044, 1'b1);
        chk(host_i.oe_seen, 1'b0, "data-out with readback off");
        wr3(SOFT_RESET_ADDR, 9'($urandom), 1'b1);
        chk(w_soft, 1'b1, "soft reset pulse");
        chk(rb_ctrl, RB_CTRL_RST, "readback control after soft reset");
        $display("test readback off and soft reset done");
        hw_strap <= 1'b1;
        repeat (5) @(posedge clk);
        chk(hw_ctl, 1'b1, "hardware control");
        wr3(7'h22, 9'h0AA, 1'b0);
        hw_strap <= 1'b0;
        wire_strap <= 1'b0;
        repeat (5) @(posedge clk);
        chk({hw_ctl, three_w}, 2'b00, "2-wire software mode");
        $display("test hardware mode done");
        wr2(1'b0, TWI_ADDR_LOW, RB_CTRL_ADDR, 9'h01D, 1'b0, 3'b111, 1'b1);
        wr2(1'b1, TWI_ADDR_HIGH, 7'h12, 9'h155, 1'b0, 3'b111, 1'b1);
        wr2(1'b1, TWI_ADDR_HIGH, 7'h12, 9'h0F0, 1'b0, 3'b111, 1'b1);
        chk(host_i.rb_byte, exp_rb(7'h12, 9'h01D), "2-wire readback");
        wr2(1'b1, TWI_ADDR_LOW, 7'h12, 9'h000, 1'b0, 3'b000, 1'b0);
        wr2(1'b0, TWI_ADDR_LOW, 7'h13, 9'h1FF, 1'b1, 3'b011, 1'b0);
        wr2(1'b0, TWI_ADDR_LOW, 7'h14, 9'h101, 1'b0, 3'b111, 1'b1);
        $display("test 2-wire done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
